// ==== logic/jump_branch_pkg.sv ====
/*
 * Constants of the microcore jump and branch unit: opcode patterns,
 * field positions, condition codes and reset values.
 * Assumes a 16-bit instruction word and a Code RAM address of at most 16 bits.
 */
`default_nettype none

package jump_branch_pkg;

  // Instruction word
  localparam int INSTR_W = 16;
  localparam int COND_W = 6;
  localparam int REL_OFFSET_W = 5;
  localparam int JUMP_REG_COUNT = 2;

  // Unconditional absolute jump: bits 15..4 fixed, bit 3 select, bits 2..0 fixed
  localparam logic [11:0] ABS_JUMP_HIGH = 12'h39A;
  localparam logic [2:0] ABS_JUMP_LOW = 3'h5;
  localparam int ABS_SEL_POS = 3;

  // Unconditional relative jump: bits 15..5 fixed, bits 4..0 offset
  localparam logic [10:0] REL_JUMP_OP = 11'h178;

  // Conditional absolute jump: bits 15..11 fixed, 10..5 code, 4 select, 3..0 zero
  localparam logic [4:0] COND_JUMP_OP = 5'h07;
  localparam int COND_FIELD_LSB = 5;
  localparam int COND_SEL_POS = 4;
  localparam logic [3:0] COND_LOW_ZERO = 4'h0;

  // Condition codes
  localparam logic [5:0] COND_FLAG_LOW = 6'h00;
  localparam logic [5:0] COND_FLAG_HIGH = 6'h10;
  localparam logic [5:0] COND_TERM_COUNT = 6'h20;
  localparam logic [5:0] COND_START_LOW = 6'h24;
  localparam logic [5:0] COND_START_HIGH = 6'h25;
  localparam logic [5:0] COND_SC_DRAIN_LOW = 6'h26;
  localparam logic [5:0] COND_SC_SOURCE_LOW = 6'h29;
  localparam logic [5:0] COND_SC_DRAIN_HIGH = 6'h2C;
  localparam logic [5:0] COND_ALU_DONE = 6'h2F;
  localparam logic [5:0] COND_BOOST_HIGH = 6'h30;
  localparam logic [5:0] COND_BOOST_LOW = 6'h31;
  localparam logic [5:0] COND_CUR_HIGH = 6'h32;
  localparam logic [5:0] COND_CUR_LOW = 6'h38;
  localparam logic [5:0] COND_OWN_HIGH = 6'h3E;
  localparam logic [5:0] COND_OWN_LOW = 6'h3F;

  // Values after reset
  localparam logic [15:0] PC_RESET_VALUE = 16'h0000;

endpackage

`default_nettype wire

// ==== logic/microcore_jump_branch_unit.sv ====
/*
 * Jump and branch unit of one microcore: decodes the three jump
 * instructions and owns the program counter that fetches from Code RAM.
 * Assumes the instruction on instr was fetched from program_counter and that
 * instructions other than these jumps simply advance to the next address.
 */
`timescale 1ns/1ps
`default_nettype none

module microcore_jump_branch_unit #(
  parameter int ADDR_W = 10
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Instruction from Code RAM
  input wire logic instr_valid,
  input wire logic [jump_branch_pkg::INSTR_W-1:0] instr,
  // Jump address registers
  input wire logic [jump_branch_pkg::JUMP_REG_COUNT-1:0][ADDR_W-1:0] jump_address_regs,
  // Condition sources
  input wire logic [15:0] flags,
  input wire logic [3:0] terminal_counts,
  input wire logic start_in,
  input wire logic [2:0] shortcut_drain_fb,
  input wire logic [2:0] shortcut_source_fb,
  input wire logic alu_op_done,
  input wire logic boost_level,
  input wire logic [5:0] current_sense,
  input wire logic own_current_fb,
  // Fetch side
  output logic [ADDR_W-1:0] program_counter,
  output logic jump_taken
);

  localparam logic [ADDR_W-1:0] PC_STEP = {{(ADDR_W-1){1'b0}}, 1'b1};

  logic [ADDR_W-1:0] program_counter_reg;
  logic [ADDR_W-1:0] program_counter_next;
  logic jump_taken_reg;
  logic jump_taken_next;
  logic abs_hit;
  logic rel_hit;
  logic cond_hit;
  logic [jump_branch_pkg::COND_W-1:0] cond_code;
  logic [63:0] cond_vec;
  logic cond_true;
  logic [ADDR_W-1:0] pc_inc;
  logic [ADDR_W-1:0] rel_ext;
  logic [ADDR_W-1:0] rel_target;
  logic [ADDR_W-1:0] abs_target;
  logic [ADDR_W-1:0] cond_target;
  logic [ADDR_W-1:0] reg_one;

  ////////////////////////////////////////////////////////////////////////////
  // Decode

  always_comb
  begin
    abs_hit = (instr[15:4] == jump_branch_pkg::ABS_JUMP_HIGH)
              && (instr[2:0] == jump_branch_pkg::ABS_JUMP_LOW);
    rel_hit = (instr[15:5] == jump_branch_pkg::REL_JUMP_OP);
    // Low nibble zero keeps this apart from the absolute jump's code space
    cond_hit = (instr[15:11] == jump_branch_pkg::COND_JUMP_OP)
               && (instr[3:0] == jump_branch_pkg::COND_LOW_ZERO);
    cond_code = instr[jump_branch_pkg::COND_FIELD_LSB +: jump_branch_pkg::COND_W];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Condition table, one bit per code

  always_comb
  begin
    cond_vec = 64'h0;
    cond_vec[jump_branch_pkg::COND_FLAG_LOW +: 16] = ~flags;
    cond_vec[jump_branch_pkg::COND_FLAG_HIGH +: 16] = flags;
    cond_vec[jump_branch_pkg::COND_TERM_COUNT +: 4] = terminal_counts;
    cond_vec[jump_branch_pkg::COND_START_LOW] = ~start_in;
    cond_vec[jump_branch_pkg::COND_START_HIGH] = start_in;
    cond_vec[jump_branch_pkg::COND_SC_DRAIN_LOW +: 3] = ~shortcut_drain_fb;
    cond_vec[jump_branch_pkg::COND_SC_SOURCE_LOW +: 3] = ~shortcut_source_fb;
    cond_vec[jump_branch_pkg::COND_SC_DRAIN_HIGH +: 3] = shortcut_drain_fb;
    cond_vec[jump_branch_pkg::COND_ALU_DONE] = alu_op_done;
    cond_vec[jump_branch_pkg::COND_BOOST_HIGH] = boost_level;
    cond_vec[jump_branch_pkg::COND_BOOST_LOW] = ~boost_level;
    cond_vec[jump_branch_pkg::COND_CUR_HIGH +: 6] = current_sense;
    cond_vec[jump_branch_pkg::COND_CUR_LOW +: 6] = ~current_sense;
    cond_vec[jump_branch_pkg::COND_OWN_HIGH] = own_current_fb;
    cond_vec[jump_branch_pkg::COND_OWN_LOW] = ~own_current_fb;
    cond_true = cond_vec[cond_code];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Targets

  always_comb
  begin
    pc_inc = program_counter_reg + PC_STEP;
    // Wraps modulo the Code RAM size; no range check on the sum
    rel_ext = {{(ADDR_W-jump_branch_pkg::REL_OFFSET_W){instr[4]}}, instr[4:0]};
    rel_target = program_counter_reg + rel_ext;
    abs_target = jump_address_regs[instr[jump_branch_pkg::ABS_SEL_POS]];
    cond_target = jump_address_regs[instr[jump_branch_pkg::COND_SEL_POS]];
    reg_one = jump_address_regs[1];
  end

  always_comb
  begin
    program_counter_next = pc_inc;
    jump_taken_next = 1'b0;
    if (abs_hit)
    begin
      program_counter_next = abs_target;
      jump_taken_next = 1'b1;
    end
    else if (rel_hit)
    begin
      program_counter_next = rel_target;
      jump_taken_next = 1'b1;
    end
    else if (cond_hit && cond_true)
    begin
      program_counter_next = cond_target;
      jump_taken_next = 1'b1;
    end
    else
    begin
      program_counter_next = pc_inc;
      jump_taken_next = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Program counter

  // Holds while no instruction is presented, so fetch stalls are safe
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
      program_counter_reg <= jump_branch_pkg::PC_RESET_VALUE[ADDR_W-1:0];
    else if (instr_valid)
      program_counter_reg <= program_counter_next;
  end

  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
      jump_taken_reg <= 1'b0;
    else
      jump_taken_reg <= instr_valid && jump_taken_next;
  end

  assign program_counter = program_counter_reg;
  assign jump_taken = jump_taken_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  chk_abs_jump_load: assert property (
    instr_valid && abs_hit |=> jump_taken && program_counter == $past(abs_target))
    else $error("absolute jump did not load jump register");

  chk_abs_select_one: assert property (
    instr_valid && abs_hit && instr[3] |=> program_counter == $past(reg_one))
    else $error("absolute jump selected wrong register");

  chk_rel_always_taken: assert property (
    instr_valid && rel_hit |=> jump_taken)
    else $error("relative jump not taken");

  chk_rel_target_sum: assert property (
    instr_valid && rel_hit |=> program_counter == $past(rel_target))
    else $error("relative jump target wrong");

  chk_plain_advance: assert property (
    instr_valid && !rel_hit && !abs_hit && !cond_hit
    |=> !jump_taken && program_counter == $past(pc_inc))
    else $error("non-jump did not advance by one");

  chk_cond_jump_taken: assert property (
    instr_valid && cond_hit && cond_true
    |=> jump_taken && program_counter == $past(cond_target))
    else $error("conditional jump not taken");

  chk_flag_low_code: assert property (
    cond_code < jump_branch_pkg::COND_FLAG_HIGH |-> cond_true == !flags[cond_code[3:0]])
    else $error("flag low condition wrong");

  chk_start_high_code: assert property (
    cond_code == jump_branch_pkg::COND_START_HIGH |-> cond_true == start_in)
    else $error("start condition wrong");

  chk_alu_done_code: assert property (
    cond_code == jump_branch_pkg::COND_ALU_DONE |-> cond_true == alu_op_done)
    else $error("alu done condition wrong");

  chk_cur_low_code: assert property (
    cond_code == jump_branch_pkg::COND_CUR_LOW |-> cond_true == !current_sense[0])
    else $error("current low condition wrong");

  chk_own_fb_code: assert property (
    cond_code == jump_branch_pkg::COND_OWN_LOW |-> cond_true == !own_current_fb)
    else $error("own current condition wrong");

  chk_cond_format_bits: assert property (
    instr_valid && instr[15:11] == jump_branch_pkg::COND_JUMP_OP && instr[3:0] != 4'h0
    && !abs_hit |=> !jump_taken)
    else $error("malformed conditional jump taken");

  chk_cond_fall_through: assert property (
    instr_valid && cond_hit && !cond_true
    |=> !jump_taken && program_counter == $past(pc_inc))
    else $error("false condition did not fall through");

  chk_stall_hold: assert property (
    !instr_valid |=> $stable(program_counter) && !jump_taken)
    else $error("program counter moved while stalled");

  cov_abs_jump: cover property (instr_valid && abs_hit);
  cov_rel_back: cover property (instr_valid && rel_hit && instr[4]);
  cov_cond_taken: cover property (instr_valid && cond_hit && cond_true);
  cov_cond_not: cover property (instr_valid && cond_hit && !cond_true);

endmodule

`default_nettype wire

// ==== testbench/code_ram_model.sv ====
/*
 * Code RAM model on the fetch side of the jump unit: returns the word held
 * at the program counter.
 * Assumes the bench writes the words it wants fetched straight into mem.
 */
`timescale 1ns/1ps
`default_nettype none

module code_ram_model #(
  parameter int ADDR_W = 10
) (
  // Fetch address
  input wire logic [ADDR_W-1:0] program_counter,
  // Fetched word
  output logic [jump_branch_pkg::INSTR_W-1:0] instr
);
  ////////////////////////////////////////////////////////////////////////
  // Unwritten words decode as no jump, so stray fetches only step by one
  logic [15:0] mem [0:(1<<ADDR_W)-1];

  initial
  begin
    for (int i = 0; i < (1 << ADDR_W); i++)
    begin
      mem[i] = 16'hFFFF;
    end
  end

  assign instr = mem[program_counter];
endmodule

`default_nettype wire

// ==== testbench/microcore_jump_branch_unit_tb.sv ====
/*
 * Self-checking bench of the jump unit: relative, absolute and all 64
 * conditional jump codes, each condition both true and false, then a
 * reset in mid-run.
 * Assumes a one-cycle answer and a one-step advance for any non-jump word.
 */
`timescale 1ns/1ps
`default_nettype none

module microcore_jump_branch_unit_tb;
  localparam int AW = 10;
  logic sys_clk = 1'b0;
  logic sys_rst, instr_valid, start_in, alu_op_done, boost_level, own_current_fb, jump_taken;
  logic [15:0] instr, flags;
  logic [1:0][AW-1:0] jump_address_regs;
  logic [3:0] terminal_counts;
  logic [2:0] shortcut_drain_fb, shortcut_source_fb;
  logic [5:0] current_sense;
  logic [AW-1:0] program_counter;
  int failures = 0;
  int comparisons = 0;

  always #50 sys_clk = ~sys_clk;

  microcore_jump_branch_unit #(.ADDR_W(AW)) microcore_jump_branch_unit_inst (.sys_clk, .sys_rst,
    .instr_valid, .instr, .jump_address_regs, .flags, .terminal_counts, .start_in,
    .shortcut_drain_fb, .shortcut_source_fb, .alu_op_done, .boost_level, .current_sense,
    .own_current_fb, .program_counter, .jump_taken);
  code_ram_model #(.ADDR_W(AW)) code_ram_model_inst (.program_counter, .instr);

  ////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp)
    begin
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
      failures++;
    end
  endtask

  // Valid stays high between steps, so back-to-back words are exercised
  task automatic step(input logic [15:0] word, input logic [AW-1:0] pc, input logic jmp);
    code_ram_model_inst.mem[program_counter] = word;
    instr_valid = 1'b1;
    @(posedge sys_clk);
    #1;
    check("program_counter", 16'(pc), 16'(program_counter));
    check("jump_taken", 16'(jmp), 16'(jump_taken));
  endtask

  // Alternating patterns catch a neighbouring bit taken by mistake
  task automatic set_src(input logic inv);
    flags = 16'h5555 ^ {16{inv}};
    terminal_counts = 4'h5 ^ {4{inv}};
    start_in = !inv;
    shortcut_drain_fb = 3'h5 ^ {3{inv}};
    shortcut_source_fb = 3'h2 ^ {3{inv}};
    alu_op_done = !inv;
    boost_level = inv;
    current_sense = 6'h15 ^ {6{inv}};
    own_current_fb = !inv;
  endtask

  function automatic logic cond_true(input int c);
    if (c < 16) return !flags[c];
    else if (c < 32) return flags[c-16];
    else if (c < 36) return terminal_counts[c-32];
    else if (c < 38) return (c == 37) ? start_in : !start_in;
    else if (c < 41) return !shortcut_drain_fb[c-38];
    else if (c < 44) return !shortcut_source_fb[c-41];
    else if (c < 47) return shortcut_drain_fb[c-44];
    else if (c == 47) return alu_op_done;
    else if (c < 50) return (c == 48) ? boost_level : !boost_level;
    else if (c < 56) return current_sense[c-50];
    else if (c < 62) return !current_sense[c-56];
    else return (c == 62) ? own_current_fb : !own_current_fb;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  task automatic test_relative;
    step({jump_branch_pkg::REL_JUMP_OP, 5'h10}, 10'h3F0, 1'b1);
    step({jump_branch_pkg::REL_JUMP_OP, 5'h0F}, 10'h3FF, 1'b1);
    step({jump_branch_pkg::REL_JUMP_OP, 5'h01}, 10'h000, 1'b1);
    step({11'h179, 5'h01}, 10'h001, 1'b0);
    $display("test_relative done");
  endtask

  task automatic test_absolute;
    step({jump_branch_pkg::ABS_JUMP_HIGH, 1'b1, jump_branch_pkg::ABS_JUMP_LOW}, 10'h2AA, 1'b1);
    step({jump_branch_pkg::ABS_JUMP_HIGH, 1'b0, jump_branch_pkg::ABS_JUMP_LOW}, 10'h155, 1'b1);
    instr_valid = 1'b0;
    @(posedge sys_clk);
    #1;
    check("idle pc", 16'h0155, 16'(program_counter));
    check("idle jump", 16'h0000, 16'(jump_taken));
    $display("test_absolute done");
  endtask

  task automatic test_conditions;
    logic [AW-1:0] pc;
    logic sel;
    set_src(1'b0);
    pc = program_counter + 1'b1;
    step({jump_branch_pkg::COND_JUMP_OP, 6'h25, 1'b0, 4'h1}, pc, 1'b0);
    for (int inv = 0; inv < 2; inv++)
    begin
      set_src(inv[0]);
      for (int c = 0; c < 64; c++)
      begin
        sel = c[0];
        pc = cond_true(c) ? jump_address_regs[sel] : program_counter + 1'b1;
        step({jump_branch_pkg::COND_JUMP_OP, c[5:0], sel, 4'h0}, pc, cond_true(c));
      end
    end
    $display("test_conditions done");
  endtask

  // Reset lands without a clock edge and must drop a pending jump pulse
  task automatic test_reset;
    instr_valid = 1'b0;
    sys_rst = 1'b1;
    #1;
    check("async reset pc", 16'h0000, 16'(program_counter));
    check("async reset jump", 16'h0000, 16'(jump_taken));
    @(posedge sys_clk);
    #1;
    sys_rst = 1'b0;
    step(16'hFFFF, 10'h001, 1'b0);
    $display("test_reset done");
  endtask

  task automatic test_done;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial
  begin
    sys_rst = 1'b1;
    instr_valid = 1'b0;
    jump_address_regs = {10'h2AA, 10'h155};
    set_src(1'b0);
    repeat (6) @(posedge sys_clk);
    #1;
    sys_rst = 1'b0;
    check("reset pc", 16'h0000, 16'(program_counter));
    check("reset jump", 16'h0000, 16'(jump_taken));
    test_relative();
    test_absolute();
    test_conditions();
    test_reset();
    test_done();
  end

  // Watchdog against a stalled run
  initial
  begin
    repeat (5000) @(posedge sys_clk);
    $display("MISMATCH watchdog expected finish seen timeout");
    failures++;
    test_done();
  end
endmodule

`default_nettype wire
